// >>> logic/planner_pkg.sv
// Contract
// - Total division estimate is minimum oscillator over output.
// - Oscillator stays between 10.8000 and 12.1097 GHz.
// - Smallest power-of-two ratio; above one only if needed.
// - Power-of-two register holds exponent, ratio one is zero.
// - High-speed divider rounds up, never below minimum oscillator.
// - Ratio one, odd above 33 steps to even.
// - Oscillator is output times both dividers, window checked.
// - Feedback divider is oscillator over 55.05 MHz crystal.
// - Feedback divider is 11.32 fixed point, fraction truncated.
// - Output dividers are plain binary in 3/11-bit fields.
// - Register 24 packs exponent 6:4, high bits 2:0.
// - Register 24 bits 7 and 3 unused.
// - Register 23 low byte; 26-31 feedback bytes ascending.
// - High-speed 5-33 any, 34-2046 even only; the planner steps odd values to even at ratio one only.
// - Exponent codes 0-5 divide 1-32; 6,7 divide 32.
// - Feedback integer part stays within 60 to 2045.
package planner_pkg;

  localparam int          DIV_W        = 80;
  localparam int          DEN_W        = 48;
  localparam logic [47:0] FVCO_MIN_HZ  = 48'd10800000000;
  localparam logic [47:0] FVCO_MAX_HZ  = 48'd12109700000;
  localparam logic [47:0] XTAL_HZ      = 48'd55050000;
  localparam logic [47:0] HS_MAX       = 48'd2046;
  localparam logic [10:0] HS_MIN       = 11'd5;
  localparam logic [10:0] HS_ODD_MAX   = 11'd33;
  localparam logic [10:0] FB_INT_MIN   = 11'd60;
  localparam logic [10:0] FB_INT_MAX   = 11'd2045;
  localparam logic [2:0]  LS_EXP_MAX   = 3'h5;
  localparam logic [2:0]  LS_NONE      = 3'h7;
  localparam int          FRAC_BITS    = 32;
  localparam logic [6:0]  DIV_CYCLES   = 7'h50;

  localparam logic [7:0]  REG_HS_LOW   = 8'h17;
  localparam logic [7:0]  REG_PACKED   = 8'h18;
  localparam logic [7:0]  REG_FB0      = 8'h1a;
  localparam logic [7:0]  REG_FB1      = 8'h1b;
  localparam logic [7:0]  REG_FB2      = 8'h1c;
  localparam logic [7:0]  REG_FB3      = 8'h1d;
  localparam logic [7:0]  REG_FB4      = 8'h1e;
  localparam logic [7:0]  REG_FB5      = 8'h1f;
  localparam int          PACK_LS_LSB  = 4;
  localparam int          PACK_HS_LSB  = 0;
  localparam logic [10:0] HS_RESET     = 11'h054;
  localparam logic [2:0]  LS_RESET     = 3'h0;
  localparam logic [42:0] FB_RESET     = 43'h064_0000_0000;

  function automatic logic [47:0] ceil_shift(input logic [47:0] total, input logic [2:0] k);
    logic [47:0] mask;
    mask = (48'h1 << k) - 48'h1;
    return (total >> k) + {47'h0, |(total & mask)};
  endfunction : ceil_shift

  function automatic logic [5:0] ratio_of(input logic [2:0] code);
    return (code > LS_EXP_MAX) ? 6'h20 : 6'(6'h1 << code);
  endfunction : ratio_of

endpackage : planner_pkg

// >>> logic/div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic        start;
  logic [79:0] dividend;
  logic [47:0] divisor;
  logic        done;
  logic [79:0] quotient;
  logic [47:0] remainder;
  modport requester (output start, dividend, divisor, input done, quotient, remainder);
  modport engine    (input start, dividend, divisor, output done, quotient, remainder);
endinterface : div_if
`default_nettype wire

// >>> logic/long_divider.sv
`timescale 1ns/1ps
`default_nettype none
module long_divider
  import planner_pkg::*;
(
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // Request and result
  div_if.engine      div
);

  logic [79:0] quo;
  logic [47:0] rem;
  logic [47:0] den;
  logic [6:0]  count;
  logic        running;
  logic        done_q;

  // One quotient bit per cycle; slow but small, the planner is not timing critical
  wire  [48:0] trial      = {rem, quo[79]};
  wire         fits       = trial >= {1'b0, den};
  wire  [48:0] trial_sub  = trial - {1'b0, den};
  wire  [47:0] next_rem   = fits ? trial_sub[47:0] : trial[47:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      quo     <= '0;
      rem     <= '0;
      den     <= '0;
      count   <= '0;
      running <= 1'b0;
      done_q  <= 1'b0;
    end else if (div.start) begin
      quo     <= div.dividend;
      rem     <= '0;
      den     <= div.divisor;
      count   <= DIV_CYCLES;
      running <= 1'b1;
      done_q  <= 1'b0;
    end else if (running) begin
      quo     <= {quo[78:0], fits};
      rem     <= next_rem;
      count   <= count - 7'h1;
      running <= count != 7'h1;
      done_q  <= count == 7'h1;
    end else begin
      done_q  <= 1'b0;
    end
  end

  assign div.done      = done_q;
  assign div.quotient  = quo;
  assign div.remainder = rem;

endmodule : long_divider
`default_nettype wire

// >>> logic/divider_regs.sv
`timescale 1ns/1ps
`default_nettype none
module divider_regs
  import planner_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register access
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Planner load
  input  wire logic        load,
  input  wire logic [10:0] load_hs,
  input  wire logic [2:0]  load_ls,
  input  wire logic [42:0] load_fb,
  // Current settings
  output logic      [10:0] hs,
  output logic      [2:0]  ls,
  output logic      [42:0] fb
);

  wire        wr_hs_low = reg_wr && reg_addr == REG_HS_LOW;
  wire        wr_packed = reg_wr && reg_addr == REG_PACKED;
  wire [5:0]  wr_fb     = {6{reg_wr}} & {reg_addr == REG_FB5, reg_addr == REG_FB4,
                                          reg_addr == REG_FB3, reg_addr == REG_FB2,
                                          reg_addr == REG_FB1, reg_addr == REG_FB0};
  // Unused bits of the packed byte and of the top feedback byte read zero
  wire [7:0]  packed_byte = {1'b0, ls, 1'b0, hs[10:8]};
  wire [7:0]  read_sel  = (reg_addr == REG_HS_LOW) ? hs[7:0] :
                          (reg_addr == REG_PACKED) ? packed_byte :
                          (reg_addr == REG_FB0)    ? fb[7:0] :
                          (reg_addr == REG_FB1)    ? fb[15:8] :
                          (reg_addr == REG_FB2)    ? fb[23:16] :
                          (reg_addr == REG_FB3)    ? fb[31:24] :
                          (reg_addr == REG_FB4)    ? fb[39:32] :
                          (reg_addr == REG_FB5)    ? {5'h00, fb[42:40]} : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hs <= HS_RESET;
      ls <= LS_RESET;
      fb <= FB_RESET;
    end else if (load) begin
      hs <= load_hs;
      ls <= load_ls;
      fb <= load_fb;
    end else begin
      if (wr_hs_low) hs[7:0] <= reg_wdata;
      if (wr_packed) begin
        ls        <= reg_wdata[PACK_LS_LSB +: 3];
        hs[10:8]  <= reg_wdata[PACK_HS_LSB +: 3];
      end
      for (int i = 0; i < 5; i++) begin
        if (wr_fb[i]) fb[i*8 +: 8] <= reg_wdata;
      end
      if (wr_fb[5]) fb[42:40] <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) reg_rdata <= 8'h00;
    else     reg_rdata <= read_sel;
  end

endmodule : divider_regs
`default_nettype wire

// >>> logic/divider_setting_planner.sv
`timescale 1ns/1ps
`default_nettype none
module divider_setting_planner
  import planner_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Frequency request
  input  wire logic        plan_start,
  input  wire logic [31:0] request_hz,
  // Planner status
  output logic             plan_busy,
  output logic             plan_done,
  output logic             plan_unachievable,
  // Register access
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Divider settings in force
  output logic      [10:0] high_speed_divider,
  output logic      [2:0]  power2_output_divider,
  output logic      [5:0]  power2_ratio,
  output logic      [10:0] feedback_integer_part,
  output logic      [31:0] feedback_fraction_part
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EST,
    ST_WAIT_EST,
    ST_PICK,
    ST_FB,
    ST_WAIT_FB,
    ST_CHECK
  } state_t;

  state_t      state;
  logic [31:0] fout_q;
  logic [47:0] total_q;
  logic [2:0]  ls_q;
  logic [10:0] hs_q;
  logic [47:0] vco_q;
  logic [42:0] fb_q;
  logic        load_q;
  logic [42:0] fb_now;

  div_if div ();

  long_divider u_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .div     (div.engine)
  );

  divider_regs u_regs (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .load      (load_q),
    .load_hs   (hs_q),
    .load_ls   (ls_q),
    .load_fb   (fb_q),
    .hs        (high_speed_divider),
    .ls        (power2_output_divider),
    .fb        (fb_now)
  );

  assign feedback_integer_part  = fb_now[42:32];
  assign feedback_fraction_part = fb_now[31:0];

  ////////////////////////////////////////////////////////////////////////////////

  // Estimate uses the lowest oscillator so the plan sits at the low end
  wire         est_start   = state == ST_EST;
  wire         fb_start    = state == ST_FB;
  wire [47:0]  est_ceil    = div.quotient[47:0] + {47'h0, |div.remainder};

  // Search from the top so the smallest workable exponent wins
  function automatic logic [2:0] ls_search(input logic [47:0] total);
    logic [2:0] k;
    k = LS_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (ceil_shift(total, 3'(i)) <= HS_MAX) k = 3'(i);
    end
    return k;
  endfunction : ls_search

  wire [2:0]   pick_ls     = ls_search(total_q);
  wire         pick_found  = pick_ls != LS_NONE;
  wire [47:0]  pick_base   = ceil_shift(total_q, pick_ls);
  wire [10:0]  hs_raw      = (pick_base[10:0] < HS_MIN) ? HS_MIN : pick_base[10:0];
  wire         hs_bad_odd  = pick_ls == 3'h0 && hs_raw > HS_ODD_MAX && hs_raw[0];
  wire [10:0]  hs_fix      = hs_bad_odd ? hs_raw + 11'h1 : hs_raw;
  wire [47:0]  vco_prod    = 48'({16'h0, fout_q} * {37'h0, hs_fix});
  wire [47:0]  vco_calc    = vco_prod << pick_ls;
  wire         vco_ok      = vco_calc >= FVCO_MIN_HZ && vco_calc <= FVCO_MAX_HZ;
  wire         pick_ok     = pick_found && vco_ok;

  // Quotient of the shifted oscillator is already 11.32, fraction truncated
  wire [42:0]  fb_calc     = div.quotient[42:0];
  wire         fb_fits     = div.quotient[79:43] == '0;
  wire [10:0]  fb_int      = fb_q[42:32];
  wire         fb_ok       = fb_int >= FB_INT_MIN && fb_int <= FB_INT_MAX;

  assign div.start    = est_start || fb_start;
  assign div.dividend = est_start ? {32'h0, FVCO_MIN_HZ} : {vco_q, 32'h0};
  assign div.divisor  = est_start ? {16'h0, fout_q} : XTAL_HZ;

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state             <= ST_IDLE;
      fout_q            <= '0;
      total_q           <= '0;
      ls_q              <= '0;
      hs_q              <= '0;
      vco_q             <= '0;
      fb_q              <= '0;
      load_q            <= 1'b0;
      plan_busy         <= 1'b0;
      plan_done         <= 1'b0;
      plan_unachievable <= 1'b0;
    end else begin
      load_q    <= 1'b0;
      plan_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (plan_start) begin
            fout_q            <= request_hz;
            plan_unachievable <= 1'b0;
            // A zero request has no divider at all
            if (request_hz == 32'h0) begin
              plan_done         <= 1'b1;
              plan_unachievable <= 1'b1;
            end else begin
              plan_busy <= 1'b1;
              state     <= ST_EST;
            end
          end
        end
        ST_EST: state <= ST_WAIT_EST;
        ST_WAIT_EST: begin
          if (div.done) begin
            total_q <= est_ceil;
            state   <= ST_PICK;
          end
        end
        ST_PICK: begin
          ls_q  <= pick_ls;
          hs_q  <= hs_fix;
          vco_q <= vco_calc;
          if (pick_ok) begin
            state <= ST_FB;
          end else begin
            plan_busy         <= 1'b0;
            plan_done         <= 1'b1;
            plan_unachievable <= 1'b1;
            state             <= ST_IDLE;
          end
        end
        ST_FB: state <= ST_WAIT_FB;
        ST_WAIT_FB: begin
          if (div.done) begin
            fb_q  <= fb_fits ? fb_calc : '1;
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          plan_busy         <= 1'b0;
          plan_done         <= 1'b1;
          plan_unachievable <= !fb_ok;
          load_q            <= fb_ok;
          state             <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Codes above five saturate at divide by 32
  always_ff @(posedge ref_clk) begin
    if (rst) power2_ratio <= 6'h01;
    else     power2_ratio <= ratio_of(power2_output_divider);
  end

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  wire         plan_ok   = plan_done && !plan_unachievable;
  wire [79:0]  fb_lo     = 80'({37'h0, fb_q} * {32'h0, XTAL_HZ});
  wire [79:0]  fb_hi     = 80'({37'h0, fb_q + 43'h1} * {32'h0, XTAL_HZ});
  wire [79:0]  vco_shift = {vco_q, 32'h0};
  wire [79:0]  est_lo    = 80'({32'h0, total_q} * {48'h0, fout_q});
  wire [79:0]  est_below = 80'({32'h0, total_q - 48'h1} * {48'h0, fout_q});
  wire [47:0]  vco_check = 48'({16'h0, fout_q} * {37'h0, hs_q}) << ls_q;
  wire [47:0]  vco_below = 48'({16'h0, fout_q} * {37'h0, hs_q - 11'h1}) << ls_q;

  a_ratio_decode: assert property (
    ##1 power2_ratio == ratio_of($past(power2_output_divider)))
    else $error("power-of-two ratio does not follow its code");

  a_est_minimum: assert property (plan_ok |->
    est_lo >= {32'h0, FVCO_MIN_HZ} && est_below < {32'h0, FVCO_MIN_HZ})
    else $error("total division estimate not minimal");

  a_ls_smallest: assert property (plan_ok && ls_q != 3'h0 |->
    ceil_shift(total_q, ls_q - 3'h1) > HS_MAX)
    else $error("power-of-two ratio larger than needed");

  a_hs_legal: assert property (plan_ok |->
    hs_q >= HS_MIN && {37'h0, hs_q} <= HS_MAX &&
    !(ls_q == 3'h0 && hs_q > HS_ODD_MAX && hs_q[0]))
    else $error("high-speed divider out of its legal set");

  a_vco_window: assert property (plan_ok |->
    vco_q == vco_check && vco_q >= FVCO_MIN_HZ && vco_q <= FVCO_MAX_HZ)
    else $error("oscillator frequency outside window");

  a_fb_quotient: assert property (plan_ok |->
    fb_lo <= vco_shift && fb_hi > vco_shift)
    else $error("feedback divider is not the truncated quotient");

  a_fb_int_range: assert property (plan_ok |->
    fb_int >= FB_INT_MIN && fb_int <= FB_INT_MAX)
    else $error("feedback integer part out of range");

  a_load_settings: assert property (plan_ok |=>
    high_speed_divider == hs_q && power2_output_divider == ls_q &&
    {feedback_integer_part, feedback_fraction_part} == fb_q)
    else $error("planned settings not loaded");

  a_fail_no_load: assert property (plan_done && plan_unachievable && !reg_wr |=>
    $stable(high_speed_divider) && $stable(fb_now) && !load_q)
    else $error("unachievable plan changed the registers");

  a_packed_read: assert property (reg_addr == REG_PACKED && !reg_wr && !load_q |=>
    reg_rdata == {1'b0, $past(power2_output_divider), 1'b0, $past(high_speed_divider[10:8])})
    else $error("packed register reads wrong");

  a_done_bounded: assert property ($rose(plan_busy) |-> ##[1:170] plan_done)
    else $error("plan did not finish in time");

  a_busy_state: assert property (
    plan_busy == (state != ST_IDLE))
    else $error("busy flag disagrees with planner state");

  a_take_busy: assert property (
    plan_start && !plan_busy && request_hz != 32'h0 |=>
    plan_busy && !plan_done)
    else $error("accepted request did not start");

  a_zero_request: assert property (
    plan_start && !plan_busy && request_hz == 32'h0 |=>
    plan_done && plan_unachievable && !plan_busy)
    else $error("zero request not refused at once");

  a_unach_hold: assert property (
    !(plan_start && !plan_busy) |=>
    plan_done || $stable(plan_unachievable))
    else $error("unachievable flag moved without done");

  a_load_only_ok: assert property (
    load_q |->
    plan_done && !plan_unachievable)
    else $error("settings loaded by a failed plan");

  a_ls_fits: assert property (
    plan_ok |->
    ls_q <= LS_EXP_MAX && ceil_shift(total_q, ls_q) <= HS_MAX)
    else $error("power-of-two code cannot carry the division");

  a_hs_nearest: assert property (
    plan_ok |->
    hs_q == HS_MIN || vco_below < FVCO_MIN_HZ ||
    (ls_q == 3'h0 && hs_q - 11'h1 > HS_ODD_MAX && !hs_q[0]))
    else $error("high-speed divider not the nearest legal value");

  // Host side; a planner load on the same edge wins, so writes are checked without one

  a_hs_write: assert property (
    reg_wr && !load_q && reg_addr == REG_HS_LOW |=>
    high_speed_divider[7:0] == $past(reg_wdata))
    else $error("high-speed low byte write lost");

  a_packed_write: assert property (
    reg_wr && !load_q && reg_addr == REG_PACKED |=>
    power2_output_divider == $past(reg_wdata[6:4]) &&
    high_speed_divider[10:8] == $past(reg_wdata[2:0]))
    else $error("packed register write lost");

  a_fb_low_write: assert property (
    reg_wr && !load_q && reg_addr == REG_FB0 |=>
    feedback_fraction_part[7:0] == $past(reg_wdata))
    else $error("feedback low byte write lost");

  a_fb_mid_write: assert property (
    reg_wr && !load_q && reg_addr == REG_FB3 |=>
    feedback_fraction_part[31:24] == $past(reg_wdata))
    else $error("feedback byte three write lost");

  a_fb_top_write: assert property (
    reg_wr && !load_q && reg_addr == REG_FB5 |=>
    feedback_integer_part[10:8] == $past(reg_wdata[2:0]))
    else $error("feedback top bits write lost");

  a_hs_low_read: assert property (
    reg_addr == REG_HS_LOW |=>
    reg_rdata == $past(high_speed_divider[7:0]))
    else $error("high-speed low byte reads wrong");

  a_fb_low_read: assert property (
    reg_addr == REG_FB0 |=>
    reg_rdata == $past(feedback_fraction_part[7:0]))
    else $error("feedback low byte reads wrong");

  a_fb_b4_read: assert property (
    reg_addr == REG_FB4 |=>
    reg_rdata == $past(fb_now[39:32]))
    else $error("feedback byte four reads wrong");

  a_fb_top_read: assert property (
    reg_addr == REG_FB5 |=>
    reg_rdata == {5'h00, $past(fb_now[42:40])})
    else $error("feedback top byte reads wrong");

  c_plan_ratio_one: cover property (plan_ok && ls_q == 3'h0);
  c_plan_ratio_big: cover property (plan_ok && ls_q != 3'h0);
  c_plan_failed:    cover property (plan_done && plan_unachievable && fout_q != 32'h0);
  c_host_write:     cover property (reg_wr && reg_addr == REG_PACKED);
  c_plan_odd_step:  cover property (plan_ok && ls_q == 3'h0 && hs_q > HS_ODD_MAX);

endmodule : divider_setting_planner
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic       ref_clk,
  // Register bus
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Entered and left just after a rising edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b0;
    // Released data shows the inverse, never a stale copy
    reg_wdata = ~d;
    @(posedge ref_clk);
    #1;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    repeat (2) @(posedge ref_clk);
    #1;
    d = reg_rdata;
  endtask : read_reg

  ////////////////////////////////////////////////////////////////////////
  // Full divider update, bytes in ascending register order
  task automatic load_plan(input logic [10:0] hs, input logic [2:0] code,
                           input logic [42:0] fb);
    write_reg(8'h17, hs[7:0]);
    write_reg(8'h18, {1'b0, code, 1'b0, hs[10:8]});
    for (int i = 0; i < 6; i++) begin
      write_reg(8'h1a + 8'(i), 8'(fb >> (8 * i)));
    end
  endtask : load_plan
endmodule : host_model
`default_nettype wire

// >>> tb/divider_setting_planner_bench.sv
`timescale 1ns/1ps
`default_nettype none
module divider_setting_planner_bench;
  localparam logic [31:0] FREQS [12] = '{32'd156750000, 32'd10000000, 32'd1000000,
    32'd200000, 32'd7000000, 32'd400000000, 32'd1500000000, 32'd330000, 32'd600000,
    32'd3000000000, 32'd100, 32'd0};
  localparam int          LATS  [12] = '{166, 166, 166, 166, 166, 166, 166, 166, 166,
    83, 83, 0};

  logic        ref_clk;
  logic        rst;
  logic        plan_start;
  logic [31:0] request_hz;
  logic        plan_busy;
  logic        plan_done;
  logic        plan_unachievable;
  logic        reg_wr;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [10:0] hs_o;
  logic [2:0]  code_o;
  logic [5:0]  ratio_o;
  logic [10:0] fbi_o;
  logic [31:0] fbf_o;
  logic [10:0] e_hs   = 11'h054;
  logic [2:0]  e_code = 3'h0;
  logic [42:0] e_fb   = 43'h064_0000_0000;
  int          mismatches = 0;
  int          tests_run  = 0;

  divider_setting_planner dut (.ref_clk(ref_clk), .rst(rst), .plan_start(plan_start),
    .request_hz(request_hz), .plan_busy(plan_busy), .plan_done(plan_done),
    .plan_unachievable(plan_unachievable), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .high_speed_divider(hs_o),
    .power2_output_divider(code_o), .power2_ratio(ratio_o),
    .feedback_integer_part(fbi_o), .feedback_fraction_part(fbf_o));

  host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  // Independent integer reference of the planning steps
  task automatic ref_plan(input logic [31:0] f, output logic ok, output logic [10:0] hs,
                          output logic [2:0] code, output logic [42:0] fb);
    logic [79:0] tot;
    logic [79:0] h;
    logic [79:0] v;
    logic [79:0] q;
    ok = 1'b0;
    code = 3'h0;
    if (f == 32'h0) return;
    tot = (80'd10800000000 + 80'(f) - 80'd1) / 80'(f);
    for (int k = 5; k >= 0; k--) begin
      if (((tot + (80'h1 << k) - 80'd1) >> k) <= 80'd2046) code = 3'(k);
    end
    h = (tot + (80'h1 << code) - 80'd1) >> code;
    if (h < 80'd5) h = 80'd5;
    if (code == 3'h0 && h > 80'd33 && h[0]) h = h + 80'd1;
    v = (80'(f) * h) << code;
    q = (v << 32) / 80'd55050000;
    hs = h[10:0];
    fb = q[42:0];
    ok = tot <= 80'd65472 && v >= 80'd10800000000 && v <= 80'd12109700000
         && q[79:32] >= 80'd60 && q[79:32] <= 80'd2045;
  endtask : ref_plan

  // Outputs in force and every divider register against e_*
  task automatic check_state();
    logic [7:0] d;
    logic [7:0] a;
    logic [7:0] ex;
    check("high_speed_divider", 64'(hs_o), 64'(e_hs));
    check("power2_output_divider", 64'(code_o), 64'(e_code));
    check("feedback_integer_part", 64'(fbi_o), 64'(e_fb[42:32]));
    check("feedback_fraction_part", 64'(fbf_o), 64'(e_fb[31:0]));
    for (int i = 0; i < 8; i++) begin
      a = (i < 2) ? 8'h17 + 8'(i) : 8'h18 + 8'(i);
      ex = (i == 0) ? e_hs[7:0] : (i == 1) ? {1'b0, e_code, 1'b0, e_hs[10:8]}
         : 8'(e_fb >> (8 * (i - 2)));
      host.read_reg(a, d);
      check($sformatf("register %h", a), 64'(d), 64'(ex));
    end
    // Ratio trails the code by a cycle, so it is looked at last
    check("power2_ratio", 64'(ratio_o), (e_code > 3'h5) ? 64'd32 : 64'd1 << e_code);
  endtask : check_state

  task automatic wait_done(inout int n);
    while (plan_done !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////////
  task automatic reset_scenario();
    check("plan_busy", 64'(plan_busy), 64'd0);
    check("plan_done", 64'(plan_done), 64'd0);
    check("plan_unachievable", 64'(plan_unachievable), 64'd0);
    check_state();
  endtask : reset_scenario

  task automatic run_plan(input logic [31:0] f, input int lat);
    logic        ok;
    logic [10:0] hs;
    logic [2:0]  code;
    logic [42:0] fb;
    int          n;
    ref_plan(f, ok, hs, code, fb);
    plan_start = 1'b1;
    request_hz = f;
    @(posedge ref_clk);
    #1;
    plan_start = 1'b0;
    n = 0;
    wait_done(n);
    check("plan latency", 64'(n), 64'(lat));
    check("plan_busy", 64'(plan_busy), 64'd0);
    check("plan_unachievable", 64'(plan_unachievable), 64'(!ok));
    if (ok) begin
      e_hs = hs;
      e_code = code;
      e_fb = fb;
    end
    @(posedge ref_clk);
    #1;
    // A failed plan must leave the previous settings untouched
    check_state();
  endtask : run_plan

  task automatic plan_scenario();
    for (int i = 0; i < 12; i++) begin
      run_plan(FREQS[i], LATS[i]);
    end
  endtask : plan_scenario

  // Start held while busy is ignored; next request right after done
  task automatic busy_scenario();
    int n;
    plan_start = 1'b1;
    request_hz = 32'd10000000;
    @(posedge ref_clk);
    #1;
    request_hz = 32'd1000000;
    repeat (20) @(posedge ref_clk);
    #1;
    plan_start = 1'b0;
    n = 20;
    wait_done(n);
    check("plan latency", 64'(n), 64'd166);
    plan_start = 1'b1;
    request_hz = 32'd156750000;
    @(posedge ref_clk);
    #1;
    plan_start = 1'b0;
    check("high_speed_divider", 64'(hs_o), 64'd1080);
    check("power2_output_divider", 64'(code_o), 64'd0);
    n = 0;
    wait_done(n);
    check("plan latency", 64'(n), 64'd166);
    @(posedge ref_clk);
    #1;
    e_hs = 11'd70;
    e_code = 3'h0;
    e_fb = 43'h0c7_519c_f2bf;
    check_state();
  endtask : busy_scenario

  task automatic reg_scenario();
    logic [7:0] d;
    host.load_plan(11'd300, 3'h2, 43'h1f4_8000_0001);
    e_hs = 11'd300;
    e_code = 3'h2;
    e_fb = 43'h1f4_8000_0001;
    check_state();
    for (int c = 0; c < 8; c++) begin
      host.write_reg(8'h18, {1'b1, 3'(c), 1'b1, 3'h5});
      host.read_reg(8'h18, d);
      check("register 18", 64'(d), 64'({1'b0, 3'(c), 1'b0, 3'h5}));
      check("power2_ratio", 64'(ratio_o), (c > 5) ? 64'd32 : 64'd1 << c);
    end
    e_code = 3'h7;
    e_hs = {3'h5, e_hs[7:0]};
    host.write_reg(8'h1f, 8'hff);
    e_fb = {3'h7, e_fb[39:0]};
    host.write_reg(8'h19, 8'haa);
    host.read_reg(8'h19, d);
    check("register 19", 64'(d), 64'd0);
    check_state();
  endtask : reg_scenario

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    plan_start = 1'b0;
    request_hz = 32'h0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    reset_scenario();
    plan_scenario();
    busy_scenario();
    reg_scenario();
    finish_test();
  end

  // Whole run needs about 2300 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
endmodule : divider_setting_planner_bench
`default_nettype wire
